//--- hdl/adsp_defines.vh
// Purpose: shared constants of the converter serial port
// Assumes: included by bare name by the port design file only, not by the fifo
// Notes:   timing counts are in master clock periods
`ifndef ADSP_DEFINES_VH
`define ADSP_DEFINES_VH

// ----------------------------------------------------------------------
// register selection codes
// ----------------------------------------------------------------------
`define ADSP_RS_COMM    2'h0
`define ADSP_RS_SETUP   2'h1
`define ADSP_RS_CLOCK   2'h2
`define ADSP_RS_DATA    2'h3

// ----------------------------------------------------------------------
// communications register fields
// ----------------------------------------------------------------------
`define ADSP_COMM_RS_HI 5
`define ADSP_COMM_RS_LO 4
`define ADSP_COMM_RW    3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ADSP_COMM_RST   8'h00
`define ADSP_SETUP_RST  8'h01
`define ADSP_CLOCK_RST  8'h05
`define ADSP_DATA_RST   16'h0000

// ----------------------------------------------------------------------
// word sizes and timing
// ----------------------------------------------------------------------
`define ADSP_BYTE_LEN   5'h08
`define ADSP_WORD_LEN   5'h10
`define ADSP_HOLD_MCLK  500

`endif

//--- hdl/adsp_fifo.v
// Purpose: conversion word buffer between filter and data register
// Assumes: DEPTH is a power of two and equals 2**AW
// Notes:   in_ready_o is registered; out side is first-word fall-through
`timescale 1ns/1ps
`default_nettype none

module adsp_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // clock and reset
    input  wire             clk_i,
    input  wire             rst_n_i,
    // fill side
    input  wire             in_valid_i,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             in_ready_o,
    // drain side
    output wire             out_valid_o,
    output wire [WIDTH-1:0] out_data_o,
    input  wire             out_ready_i
);

    localparam [AW:0] FULL = DEPTH[AW:0];

    reg  [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg  [AW-1:0]    wp_r;
    reg  [AW-1:0]    rp_r;
    reg  [AW:0]      cnt_r;
    reg              in_rdy_r;
    wire             push;
    wire             pop;
    wire [AW:0]      cnt_nxt;

    assign push        = in_valid_i & in_rdy_r;
    assign pop         = out_valid_o & out_ready_i;
    assign cnt_nxt     = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign in_ready_o  = in_rdy_r;
    assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
    assign out_data_o  = mem_r[rp_r];

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_r     <= {AW{1'b0}};
            rp_r     <= {AW{1'b0}};
            cnt_r    <= {(AW+1){1'b0}};
            in_rdy_r <= 1'b0;
        end else begin
            if (push) begin
                wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
            end
            cnt_r    <= cnt_nxt;
            in_rdy_r <= (cnt_nxt != FULL);
        end
    end

    always @(posedge clk_i) begin
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end

endmodule // adsp_fifo

`default_nettype wire

//--- hdl/adsp_port.v
// Purpose: serial host port and conversion-ready logic of the converter
// Assumes: serial pins are asynchronous to sys_clk_i and much slower
// Notes:   din sampled on serial clock rise; dout shifts on its fall, the first read bit is set on the rise ending the command
`timescale 1ns/1ps
`include "adsp_defines.vh"
`default_nettype none

module adsp_port #(
    parameter DATA_W     = 16,
    parameter FIFO_DEPTH = 32,
    parameter FIFO_AW    = 5,
    parameter MCLK_RATIO = 1
) (
    // clock and reset
    input  wire              sys_clk_i,
    input  wire              rst_n_i,
    // serial pins
    input  wire              sclk_i,
    input  wire              cs_n_i,
    input  wire              din_i,
    output wire              dout_o,
    output wire              dout_oe_o,
    output wire              conversion_ready_n_o,
    // conversion words from the filter
    input  wire              conv_valid_i,
    input  wire [DATA_W-1:0] conv_data_i,
    output wire              conv_ready_o,
    // calibration status
    input  wire              cal_done_i,
    // register contents to the converter core
    output wire [7:0]        setup_o,
    output wire [7:0]        clock_o
);

    // ------------------------------------------------------------------
    // constants
    // ------------------------------------------------------------------
    localparam [2:0]  SP_CMD   = 3'b001;
    localparam [2:0]  SP_WR    = 3'b010;
    localparam [2:0]  SP_RD    = 3'b100;
    localparam [2:0]  UP_IDLE  = 3'b001;
    localparam [2:0]  UP_HOLD  = 3'b010;
    localparam [2:0]  UP_LOAD  = 3'b100;
    localparam integer HOLD_INT = `ADSP_HOLD_MCLK * MCLK_RATIO;
    localparam [12:0]  HOLD_CYC = HOLD_INT[12:0];

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    reg sclk_s1_r;
    reg sclk_s2_r;
    reg sclk_d_r;
    reg cs_s1_r;
    reg cs_s2_r;
    reg din_s1_r;
    reg din_s2_r;

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_s1_r <= 1'b1;
            sclk_s2_r <= 1'b1;
            sclk_d_r  <= 1'b1;
            cs_s1_r   <= 1'b1;
            cs_s2_r   <= 1'b1;
            din_s1_r  <= 1'b0;
            din_s2_r  <= 1'b0;
        end else begin
            sclk_s1_r <= sclk_i;
            sclk_s2_r <= sclk_s1_r;
            sclk_d_r  <= sclk_s2_r;
            cs_s1_r   <= cs_n_i;
            cs_s2_r   <= cs_s1_r;
            din_s1_r  <= din_i;
            din_s2_r  <= din_s1_r;
        end
    end

    wire sclk_rise = sclk_s2_r & ~sclk_d_r;
    wire sclk_fall = ~sclk_s2_r & sclk_d_r;
    wire frame_act = ~cs_s2_r;

    // ------------------------------------------------------------------
    // serial state and registers
    // ------------------------------------------------------------------
    reg  [2:0]        st_r;
    reg  [4:0]        bit_cnt_r;
    reg  [4:0]        rd_len_r;
    reg  [7:0]        rx_r;
    reg  [15:0]       tx_r;
    reg  [7:0]        comm_r;
    reg  [7:0]        setup_r;
    reg  [7:0]        clock_r;
    reg  [DATA_W-1:0] data_r;
    reg               dout_r;
    reg               oe_r;
    reg               rd_done_r;
    reg  [15:0]       rd_word;

    wire [7:0] rx_byte = {rx_r[6:0], din_s2_r};
    wire [1:0] rs_new  = rx_byte[`ADSP_COMM_RS_HI:`ADSP_COMM_RS_LO];
    wire [1:0] rs_cur  = comm_r[`ADSP_COMM_RS_HI:`ADSP_COMM_RS_LO];
    wire       rd_busy = st_r[2] & (rs_cur == `ADSP_RS_DATA);

    // output shifter source, short registers left-justified
    always @* begin
        case (rs_new)
            `ADSP_RS_COMM:  rd_word = {rx_byte, 8'h00};
            `ADSP_RS_SETUP: rd_word = {setup_r, 8'h00};
            `ADSP_RS_CLOCK: rd_word = {clock_r, 8'h00};
            default:        rd_word = data_r[15:0];
        endcase
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r      <= SP_CMD;
            bit_cnt_r <= 5'h00;
            rd_len_r  <= `ADSP_BYTE_LEN;
            rx_r      <= 8'h00;
            tx_r      <= 16'h0000;
            comm_r    <= `ADSP_COMM_RST;
            setup_r   <= `ADSP_SETUP_RST;
            clock_r   <= `ADSP_CLOCK_RST;
            dout_r    <= 1'b0;
            oe_r      <= 1'b0;
            rd_done_r <= 1'b0;
        end else begin
            oe_r      <= frame_act;
            rd_done_r <= 1'b0;
            if (!frame_act) begin
                st_r      <= SP_CMD;
                bit_cnt_r <= 5'h00;
            end else if (sclk_rise) begin
                rx_r      <= rx_byte;
                bit_cnt_r <= bit_cnt_r + 5'h01;
                case (st_r)
                    SP_CMD: begin
                        if (bit_cnt_r == `ADSP_BYTE_LEN - 5'h01) begin
                            comm_r    <= rx_byte;
                            bit_cnt_r <= 5'h00;
                            if (rx_byte[`ADSP_COMM_RW]) begin
                                st_r   <= SP_RD;
                                tx_r   <= rd_word;
                                dout_r <= rd_word[15];
                                if (rs_new == `ADSP_RS_DATA) begin
                                    rd_len_r <= `ADSP_WORD_LEN;
                                end else begin
                                    rd_len_r <= `ADSP_BYTE_LEN;
                                end
                            end else begin
                                st_r <= SP_WR;
                            end
                        end
                    end
                    SP_WR: begin
                        if (bit_cnt_r == `ADSP_BYTE_LEN - 5'h01) begin
                            bit_cnt_r <= 5'h00;
                            st_r      <= SP_CMD;
                            case (rs_cur)
                                `ADSP_RS_SETUP: setup_r <= rx_byte;
                                `ADSP_RS_CLOCK: clock_r <= rx_byte;
                                `ADSP_RS_COMM:  comm_r  <= rx_byte;
                                default: begin
                                end
                            endcase
                        end
                    end
                    SP_RD: begin
                        if (bit_cnt_r == rd_len_r - 5'h01) begin
                            bit_cnt_r <= 5'h00;
                            st_r      <= SP_CMD;
                            rd_done_r <= (rs_cur == `ADSP_RS_DATA);
                        end
                    end
                    default: begin
                        st_r      <= SP_CMD;
                        bit_cnt_r <= 5'h00;
                    end
                endcase
            end else if (sclk_fall && (st_r == SP_RD)) begin
                tx_r   <= {tx_r[14:0], 1'b0};
                dout_r <= tx_r[14];
            end
        end
    end

    // ------------------------------------------------------------------
    // data register update and conversion ready
    // ------------------------------------------------------------------
    reg  [2:0]        up_r;
    reg  [12:0]       hold_cnt_r;
    reg               rdy_n_r;
    wire              fifo_valid;
    wire [DATA_W-1:0] fifo_data;
    wire              fifo_pop = (up_r == UP_LOAD);

    adsp_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk_i       (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (conv_valid_i),
        .in_data_i   (conv_data_i),
        .in_ready_o  (conv_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_data),
        .out_ready_i (fifo_pop)
    );

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            up_r       <= UP_IDLE;
            hold_cnt_r <= 13'h0000;
            rdy_n_r    <= 1'b1;
            data_r     <= `ADSP_DATA_RST;
        end else begin
            if (rd_done_r) begin
                rdy_n_r <= 1'b1;
            end
            if (cal_done_i) begin
                rdy_n_r <= 1'b0;
            end
            case (up_r)
                UP_IDLE: begin
                    // start an update only while no data word is being shifted out
                    if (fifo_valid && !rd_busy) begin
                        if (!rdy_n_r && !rd_done_r) begin
                            up_r       <= UP_HOLD;
                            rdy_n_r    <= 1'b1;
                            hold_cnt_r <= 13'h0000;
                        end else begin
                            up_r <= UP_LOAD;
                        end
                    end
                end
                UP_HOLD: begin
                    rdy_n_r <= 1'b1;
                    if (hold_cnt_r == HOLD_CYC - 13'h0001) begin
                        up_r <= UP_LOAD;
                    end else begin
                        hold_cnt_r <= hold_cnt_r + 13'h0001;
                    end
                end
                UP_LOAD: begin
                    data_r  <= fifo_data;
                    rdy_n_r <= 1'b0;
                    up_r    <= UP_IDLE;
                end
                default: begin
                    up_r <= UP_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign dout_o               = dout_r;
    assign dout_oe_o            = oe_r;
    assign conversion_ready_n_o = rdy_n_r;
    assign setup_o              = setup_r;
    assign clock_o              = clock_r;

endmodule // adsp_port

`default_nettype wire

//--- tb/adsp_port_monitor.sv
// Purpose: port checker for the converter serial port
// Assumes: single clock domain, bound to adsp_port
// Notes:   sees only the top module ports
`timescale 1ns/1ps
`default_nettype none

module adsp_port_monitor #(
    parameter MCLK_RATIO = 1
) (
    // clock and reset
    input wire logic       sys_clk_i,
    input wire logic       rst_n_i,
    // serial pins
    input wire logic       sclk_i,
    input wire logic       cs_n_i,
    input wire logic       dout_o,
    input wire logic       dout_oe_o,
    input wire logic       conversion_ready_n_o,
    // stream and status
    input wire logic       conv_valid_i,
    input wire logic       conv_ready_o,
    input wire logic       cal_done_i,
    input wire logic [7:0] setup_o,
    input wire logic [7:0] clock_o
);
    // ------------------------------------------------------------
    // helper: length of each high phase of ready
    // ------------------------------------------------------------
    localparam int HOLD_LO = 500 * MCLK_RATIO;
    localparam int HOLD_HI = HOLD_LO + 3;
    logic [15:0] hi_cnt_r;
    logic        hold_r;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hi_cnt_r <= 16'h0000;
            hold_r   <= 1'b0;
        end else begin
            hi_cnt_r <= conversion_ready_n_o ? hi_cnt_r + 16'h0001 : 16'h0000;
            if ($rose(conversion_ready_n_o))
                hold_r <= cs_n_i;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // ------------------------------------------------------------
    // sequences and assertions
    // ------------------------------------------------------------
    sequence s_push; conv_valid_i && conv_ready_o; endsequence
    sequence s_select; !cs_n_i [*5]; endsequence
    sequence s_shift_hi; (sclk_i && !cs_n_i) [*8]; endsequence
    a_cal_sets_ready: assert property (cal_done_i |=> !conversion_ready_n_o)
        else $error("ready not low after calibration");
    a_push_loads_word: assert property (s_push |-> ##[1:506] !conversion_ready_n_o)
        else $error("pushed word never reached data register");
    a_hold_length: assert property ($fell(conversion_ready_n_o) && hold_r
        |-> hi_cnt_r >= HOLD_LO && hi_cnt_r <= HOLD_HI)
        else $error("ready hold before update has wrong length");
    a_reset_values: assert property (disable iff (1'b0) !rst_n_i
        |=> setup_o == 8'h01 && clock_o == 8'h05 && conversion_ready_n_o && !dout_oe_o)
        else $error("outputs not at reset values");
    a_conv_after_reset: assert property ($rose(rst_n_i) |-> ##[0:1] conv_ready_o)
        else $error("stream not ready after reset");
    a_oe_on_select: assert property (s_select |-> dout_oe_o)
        else $error("data out not driven while selected");
    a_oe_off_idle: assert property (cs_n_i [*5] |-> !dout_oe_o)
        else $error("data out driven while deselected");
    a_dout_stable: assert property (s_shift_hi ##0 !$past(cs_n_i, 12) |-> $stable(dout_o))
        else $error("data out moved while serial clock high");
endmodule // adsp_port_monitor

bind adsp_port adsp_port_monitor #(.MCLK_RATIO(MCLK_RATIO)) i_adsp_port_monitor (
    .sys_clk_i, .rst_n_i, .sclk_i, .cs_n_i, .dout_o, .dout_oe_o, .conversion_ready_n_o,
    .conv_valid_i, .conv_ready_o, .cal_done_i, .setup_o, .clock_o
);

`default_nettype wire

//--- tb/adsp_host_model.sv
// Purpose: host serial controller driving the converter port
// Assumes: serial clock period 40 system clocks, idle high
// Notes:   clock runs only inside frames
`timescale 1ns/1ps
`default_nettype none

module adsp_host_model (
    // clock
    input  wire logic clk_i,
    // serial pins
    output var logic  sclk_o,
    output var logic  cs_n_o,
    output var logic  din_o,
    input  wire logic dout_i,
    input  wire logic dout_oe_i
);
    // released line shows the inverse of its last level
    wire logic line_w = dout_oe_i ? dout_i : ~dout_i;
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        din_o  = 1'b0;
    end
    task automatic half;
        repeat (20) @(negedge clk_i);
    endtask
    // n bits of w from bit 23 down; bits after the command are captured
    task automatic frame(input logic [23:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        cs_n_o = 1'b0;
        half();
        for (int i = 0; i < n; i++) begin
            // sample before the fall: a bit stands until the detected fall
            if (i >= 8)
                r = {r[14:0], line_w};
            sclk_o = 1'b0;
            din_o  = w[23 - i];
            half();
            sclk_o = 1'b1;
            half();
        end
        cs_n_o = 1'b1;
        din_o  = ~din_o;
        half();
    endtask
endmodule // adsp_host_model

`default_nettype wire

//--- tb/adc_serial_data_ready_port_test.sv
// Purpose: self-checking bench of the converter serial port
// Assumes: 250 MHz system clock, 160 ns serial clock
// Notes:   inputs change on the falling clock edge
`timescale 1ns/1ps
`default_nettype none

module adc_serial_data_ready_port_test;
    logic        clk        = 1'b0;
    logic        rst_n      = 1'b0;
    logic        conv_valid = 1'b0;
    logic [15:0] conv_data  = 16'h0000;
    logic        cal_done   = 1'b0;
    wire         sclk, cs_n, din, dout, dout_oe, rdy_n, conv_ready;
    wire  [7:0]  setup, clock_reg;
    int          bad_count       = 0;
    int          samples_checked = 0;
    logic [15:0] rd;
    always #2 clk = ~clk;

    adsp_port #(.MCLK_RATIO(1)) i_adsp_port (
        .sys_clk_i(clk), .rst_n_i(rst_n), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
        .dout_o(dout), .dout_oe_o(dout_oe), .conversion_ready_n_o(rdy_n),
        .conv_valid_i(conv_valid), .conv_data_i(conv_data), .conv_ready_o(conv_ready),
        .cal_done_i(cal_done), .setup_o(setup), .clock_o(clock_reg)
    );
    adsp_host_model i_adsp_host_model (
        .clk_i(clk), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout),
        .dout_oe_i(dout_oe)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic fail(input string what);
        bad_count++;
        $display("Error %s expected done seen timeout", what);
        end_of_test();
    endtask
    task automatic wait_rdy(input logic lvl, input int lim);
        int k;
        k = 0;
        while (rdy_n !== lvl && k < lim) begin
            @(negedge clk);
            k++;
        end
        if (rdy_n !== lvl)
            fail("ready wait");
    endtask
    task automatic push(input logic [15:0] w);
        conv_data  = w;
        conv_valid = 1'b1;
        @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        check("setup", 16'h0001, {8'h00, setup});
        check("clock", 16'h0005, {8'h00, clock_reg});
        check("ready", 16'h0001, {15'h0000, rdy_n});
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check("stream ready", 16'h0001, {15'h0000, conv_ready});
    endtask
    task automatic t_regs;
        i_adsp_host_model.frame(24'h10F000, 4, rd);
        i_adsp_host_model.frame(24'h10A500, 16, rd);
        check("setup", 16'h00A5, {8'h00, setup});
        i_adsp_host_model.frame(24'h203C00, 16, rd);
        check("clock", 16'h003C, {8'h00, clock_reg});
        i_adsp_host_model.frame(24'h180000, 16, rd);
        check("setup read", 16'h00A5, rd);
        i_adsp_host_model.frame(24'h280000, 16, rd);
        check("clock read", 16'h003C, rd);
        i_adsp_host_model.frame(24'h080000, 16, rd);
        check("comm read", 16'h0008, rd);
    endtask
    task automatic t_data;
        push(16'hBEEF);
        conv_valid = 1'b0;
        wait_rdy(1'b0, 10);
        i_adsp_host_model.frame(24'h38FFFF, 23, rd);
        check("ready after 15 bits", 16'h0000, {15'h0000, rdy_n});
        i_adsp_host_model.frame(24'h38FFFF, 24, rd);
        check("data read", 16'hBEEF, rd);
        check("ready after read", 16'h0001, {15'h0000, rdy_n});
    endtask
    task automatic t_fill;
        int n;
        int k;
        int rises;
        int quiet;
        logic prev;
        n = 0;
        rises = 0;
        prev = rdy_n;
        while (conv_ready === 1'b1 && n < 40) begin
            push(16'h1000 + n[15:0]);
            n++;
            if (rdy_n === 1'b1 && prev !== 1'b1)
                rises++;
            prev = rdy_n;
        end
        conv_valid = 1'b0;
        check("words taken", 16'h0021, n[15:0]);
        k = 0;
        quiet = 0;
        prev = rdy_n;
        while (quiet < 1000 && k < 20000) begin
            @(negedge clk);
            k++;
            quiet++;
            if (rdy_n !== prev) begin
                quiet = 0;
                if (rdy_n === 1'b1)
                    rises++;
            end
            prev = rdy_n;
        end
        if (quiet < 1000)
            fail("drain");
        check("update holds", 16'h0020, rises[15:0]);
        check("stream ready", 16'h0001, {15'h0000, conv_ready});
        wait_rdy(1'b0, 10);
        i_adsp_host_model.frame(24'h380000, 24, rd);
        check("last word", 16'h1020, rd);
    endtask
    task automatic t_cal;
        cal_done = 1'b1;
        @(negedge clk);
        cal_done = 1'b0;
        @(negedge clk);
        check("ready after cal", 16'h0000, {15'h0000, rdy_n});
    endtask

    initial begin
        t_reset();
        t_regs();
        t_data();
        t_fill();
        t_cal();
        t_reset();
        end_of_test();
    end
endmodule // adc_serial_data_ready_port_test

`default_nettype wire
